// >>> ivw_pkg.sv
// Constants shared by the interrupt vector and wait controller
`default_nettype none
package ivw_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] IVW_SENS_OFS = 8'h00;   // ext_irq_sensitivity_ctrl
    localparam logic [7:0] IVW_CLK_OFS = 8'h01;    // main_clock_ctrl_status
    localparam logic [7:0] IVW_PEND_OFS = 8'h02;   // external pending view
    localparam logic [7:0] IVW_SENS_RESET = 8'h00;
    localparam logic [7:0] IVW_SENS_WMASK = 8'h3F; // Bits 7:6 stay zero
    localparam int IVW_PORTA_LSB = 0;
    localparam int IVW_PORTB_LSB = 2;
    localparam int IVW_PORTC_LSB = 4;
    localparam int IVW_SLOW_BIT = 0;
    localparam int IVW_WAIT_BIT = 1;
    localparam int IVW_MASK_BIT = 2;
    // ------------------------------------------------------------
    // Sensitivity encodings
    // ------------------------------------------------------------
    localparam logic [1:0] IVW_SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] IVW_SENSE_RISE = 2'h1;
    localparam logic [1:0] IVW_SENSE_FALL = 2'h2;
    localparam logic [1:0] IVW_SENSE_BOTH = 2'h3;
    // ------------------------------------------------------------
    // Vectors and wakeup capability
    // ------------------------------------------------------------
    localparam int IVW_NVEC = 14;
    localparam logic [3:0] IVW_VEC_WAKEUP_TMR = 4'h0;
    localparam logic [3:0] IVW_VEC_PORTA = 4'h4;
    localparam logic [3:0] IVW_VEC_PORTB = 4'h5;
    localparam logic [3:0] IVW_VEC_PORTC = 4'h6;
    localparam logic [15:0] IVW_VEC0_ADDR = 16'hFFFA;
    localparam logic [13:0] IVW_PERIPH_USED = 14'h3F81;
    localparam logic [13:0] IVW_WAKE_HALT = 14'h0070;
    localparam logic [13:0] IVW_WAKE_ACTIVE = 14'h2170;
    localparam logic [13:0] IVW_WAKE_TIMED = 14'h0071;
    localparam logic [1:0] IVW_HALT_NONE = 2'h0;
    localparam logic [1:0] IVW_HALT_PLAIN = 2'h1;
    localparam logic [1:0] IVW_HALT_ACTIVE = 2'h2;
    localparam logic [1:0] IVW_HALT_TIMED = 2'h3;
    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int IVW_SLOW_DIV = 32;
    localparam logic [4:0] IVW_SLOW_LAST = 5'(IVW_SLOW_DIV - 1);
    typedef enum logic {IVW_RUN, IVW_WAIT} ivw_state_type;
endpackage : ivw_pkg
`default_nettype wire

// >>> ivw_ctrl.sv
// Interrupt vector, sensitivity, slow and wait controller
`timescale 1ns/10ps
`default_nettype none
module ivw_ctrl
    import ivw_pkg::*;
(
    input wire logic clock_in,               // 40 MHz master clock
    input wire logic rstn_in,                // Async reset, active low
    input wire logic [7:0] reg_addr_in,      // Register address
    input wire logic [7:0] reg_wdata_in,     // Register write data
    input wire logic reg_wr_in,              // Write strobe
    input wire logic reg_rd_in,              // Read strobe
    output logic [7:0] reg_rdata_out,        // Read data, next cycle
    input wire logic porta_ext_irq_in,       // Port A interrupt pin
    input wire logic portb_ext_irq_in,       // Port B interrupt pin
    input wire logic portc_ext_irq_in,       // Port C interrupt pin
    input wire logic [13:0] periph_irq_in,   // Peripheral request levels
    input wire logic wait_instruction_in,    // CPU executes wait
    input wire logic mask_set_in,            // CPU sets interrupt mask
    input wire logic mask_clear_in,          // CPU clears interrupt mask
    input wire logic cc_pop_in,              // Flags popped from stack
    input wire logic cc_pop_mask_in,         // Mask bit being popped
    input wire logic irq_ack_in,             // CPU takes the request
    input wire logic [1:0] halt_kind_in,     // Halt variant now active
    output logic irq_req_out,                // Request to CPU
    output logic [3:0] irq_vector_out,       // Vector number
    output logic [15:0] irq_addr_out,        // Vector pair high address
    output logic cc_push_out,                // Push flags pulse
    output logic cc_push_mask_out,           // Mask bit to push
    output logic imask_out,                  // Interrupt mask bit
    output logic cpu_clk_en_out,             // CPU clock enable
    output logic periph_clk_en_out,          // Peripheral clock enable
    output logic wait_out,                   // Wait state
    output logic slow_wait_out,              // Slow-wait state
    output logic halt_wake_out               // Wake request to halt logic
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    logic [7:0] sens;
    logic slow;
    logic imask;
    ivw_state_type state;
    logic [4:0] div_cnt;
    logic div_tick;
    logic [2:0] ext_pend;
    logic [2:0] next_ext_pend;
    logic sens_wr_ok;
    logic [13:0] all_pend;
    logic [13:0] active_pend;
    logic [3:0] next_vec;
    logic any_active;
    logic take;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Pins are asynchronous; edges are seen only after two flops
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
            pin_prev <= 3'h7;
        end else begin
            pin_meta <= {portc_ext_irq_in, portb_ext_irq_in,
                         porta_ext_irq_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign sens_wr_ok = reg_wr_in && (reg_addr_in == IVW_SENS_OFS)
                        && imask;

    // Reserved bits are forced to zero whatever software writes
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sens <= IVW_SENS_RESET;
        end else if (sens_wr_ok) begin
            sens <= reg_wdata_in & IVW_SENS_WMASK;
        end
    end

    // Slow select; reset leaves the undivided clock
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slow <= 1'b0;
        end else if (reg_wr_in && (reg_addr_in == IVW_CLK_OFS)) begin
            slow <= reg_wdata_in[IVW_SLOW_BIT];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            if (reg_addr_in == IVW_SENS_OFS) begin
                reg_rdata_out <= sens;
            end else if (reg_addr_in == IVW_CLK_OFS) begin
                reg_rdata_out <= {5'h00, imask, wait_out, slow};
            end else if (reg_addr_in == IVW_PEND_OFS) begin
                reg_rdata_out <= {5'h00, ext_pend};
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // External line detection
    // ------------------------------------------------------------
    // A sense change clears the line even against a new edge, so
    // software can flush a stale request; otherwise set beats ack.
    always_comb begin
        logic [1:0] fld;
        logic [1:0] nfld;
        logic rise;
        logic fall;
        logic hit;
        fld = 2'h0;
        nfld = 2'h0;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        next_ext_pend = ext_pend;
        for (int i = 0; i < 3; i++) begin
            fld = sens[2*i +: 2];
            nfld = reg_wdata_in[2*i +: 2];
            rise = pin_sync[i] && !pin_prev[i];
            fall = !pin_sync[i] && pin_prev[i];
            case (fld)
                IVW_SENSE_FALL_LOW: hit = fall || !pin_sync[i];
                IVW_SENSE_RISE: hit = rise;
                IVW_SENSE_FALL: hit = fall;
                default: hit = rise || fall;
            endcase
            if (sens_wr_ok && (nfld != fld)) begin
                next_ext_pend[i] = 1'b0;
            end else if (hit) begin
                next_ext_pend[i] = 1'b1;
            end else if (take
                         && (irq_vector_out == IVW_VEC_PORTA + 4'(i))) begin
                next_ext_pend[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_pend <= 3'h0;
        end else begin
            ext_pend <= next_ext_pend;
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    // Ports sit at vectors 4..6; reserved slots never request
    assign all_pend = (periph_irq_in & IVW_PERIPH_USED)
                      | {7'h00, ext_pend, 4'h0};
    assign active_pend = imask ? 14'h0000 : all_pend;
    assign any_active = |active_pend;
    assign take = irq_ack_in && irq_req_out;

    // Scan downward so the lowest number is the last to win
    always_comb begin
        next_vec = 4'h0;
        for (int v = IVW_NVEC - 1; v >= 0; v--) begin
            if (active_pend[v]) begin
                next_vec = 4'(v);
            end
        end
    end

    // Request stops the cycle it is taken so it cannot repeat
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_req_out <= 1'b0;
            irq_vector_out <= 4'h0;
            irq_addr_out <= IVW_VEC0_ADDR;
        end else begin
            irq_req_out <= any_active && !take && !mask_set_in;
            irq_vector_out <= next_vec;
            irq_addr_out <= IVW_VEC0_ADDR
                            - {11'h000, next_vec, 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask and flag stacking
    // ------------------------------------------------------------
    // Mask is set at reset; service saves the old value first
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            imask <= 1'b1;
            cc_push_out <= 1'b0;
            cc_push_mask_out <= 1'b0;
        end else begin
            cc_push_out <= take;
            if (take) begin
                cc_push_mask_out <= imask;
                imask <= 1'b1;
            end else if (cc_pop_in) begin
                imask <= cc_pop_mask_in;
            end else if (wait_instruction_in && state == IVW_RUN) begin
                imask <= 1'b0;
            end else if (mask_set_in) begin
                imask <= 1'b1;
            end else if (mask_clear_in) begin
                imask <= 1'b0;
            end
        end
    end
    assign imask_out = imask;

    // ------------------------------------------------------------
    // Wait state
    // ------------------------------------------------------------
    // Only an unmasked request ends wait; reset ends it too
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= IVW_RUN;
        end else begin
            case (state)
                IVW_RUN: begin
                    if (wait_instruction_in) begin
                        state <= IVW_WAIT;
                    end
                end
                IVW_WAIT: begin
                    if (any_active) begin
                        state <= IVW_RUN;
                    end
                end
                default: state <= IVW_RUN;
            endcase
        end
    end
    assign wait_out = (state == IVW_WAIT);
    assign slow_wait_out = wait_out && slow;

    // ------------------------------------------------------------
    // Slow clock divider
    // ------------------------------------------------------------
    // One enable pulse per 32 master cycles rather than a new clock
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_cnt <= 5'h00;
        end else if (!slow || div_tick) begin
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end
    assign div_tick = (div_cnt == IVW_SLOW_LAST);
    assign periph_clk_en_out = slow ? div_tick : 1'b1;
    assign cpu_clk_en_out = periph_clk_en_out && !wait_out;

    // ------------------------------------------------------------
    // Halt wakeup
    // ------------------------------------------------------------
    // Halt ignores the mask; each variant has its own waking set
    always_comb begin
        case (halt_kind_in)
            IVW_HALT_PLAIN: halt_wake_out = |(all_pend & IVW_WAKE_HALT);
            IVW_HALT_ACTIVE:
                halt_wake_out = |(all_pend & IVW_WAKE_ACTIVE);
            IVW_HALT_TIMED:
                halt_wake_out = |(all_pend & IVW_WAKE_TIMED);
            default: halt_wake_out = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [13:0] above_mask;
    assign above_mask = (14'h0001 << irq_vector_out) - 14'h0001;

    property p_vec_addr;
        @(posedge clock_in) disable iff (!rstn_in)
        irq_req_out |-> irq_addr_out
            == (IVW_VEC0_ADDR - {11'h000, irq_vector_out, 1'b0});
    endproperty
    a_vec_addr: assert property (p_vec_addr)
        else $error("vector address does not match vector number");

    property p_priority;
        @(posedge clock_in) disable iff (!rstn_in)
        irq_req_out |-> (($past(active_pend) & above_mask) == 14'h0000);
    endproperty
    a_priority: assert property (p_priority)
        else $error("a lower numbered request was passed over");

    property p_locked_write;
        @(posedge clock_in) disable iff (!rstn_in)
        (reg_wr_in && reg_addr_in == IVW_SENS_OFS && !imask)
            |=> $stable(sens);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("sense register written while mask clear");

    property p_change_clears;
        @(posedge clock_in) disable iff (!rstn_in)
        (sens_wr_ok && reg_wdata_in[1:0] != sens[1:0])
            |=> !ext_pend[0];
    endproperty
    a_change_clears: assert property (p_change_clears)
        else $error("port A pending kept across sense change");

    property p_rise_sets;
        @(posedge clock_in) disable iff (!rstn_in)
        (sens[1:0] == IVW_SENSE_RISE && pin_sync[0] && !pin_prev[0]
            && !sens_wr_ok) |=> ext_pend[0];
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge on port A not latched");

    property p_slow_gap;
        @(posedge clock_in) disable iff (!rstn_in)
        (slow && periph_clk_en_out && $past(slow))
            |=> !periph_clk_en_out [*8];
    endproperty
    a_slow_gap: assert property (p_slow_gap)
        else $error("slow enable pulses too close together");

    property p_wait_entry;
        @(posedge clock_in) disable iff (!rstn_in)
        (wait_instruction_in && !wait_out && !take && !cc_pop_in)
            |=> (wait_out && !imask && !cpu_clk_en_out);
    endproperty
    a_wait_entry: assert property (p_wait_entry)
        else $error("wait entry did not stop CPU and clear mask");

    property p_wait_exit;
        @(posedge clock_in) disable iff (!rstn_in)
        (wait_out && any_active) |=> (!wait_out ##1 irq_req_out);
    endproperty
    a_wait_exit: assert property (p_wait_exit)
        else $error("wait did not end in a request");

    property p_push;
        @(posedge clock_in) disable iff (!rstn_in)
        take |=> (cc_push_out && imask && !irq_req_out);
    endproperty
    a_push: assert property (p_push)
        else $error("service did not push flags and set mask");

    property p_slow_wait_ticks;
        @(posedge clock_in) disable iff (!rstn_in)
        (slow_wait_out && $stable(slow)) |-> ##[0:31] periph_clk_en_out;
    endproperty
    a_slow_wait_ticks: assert property (p_slow_wait_ticks)
        else $error("peripherals stopped during slow-wait");

    c_wake: cover property (@(posedge clock_in) disable iff (!rstn_in)
        wait_out ##1 !wait_out ##1 irq_req_out);
    c_slow_wait: cover property (@(posedge clock_in)
        disable iff (!rstn_in) slow_wait_out && periph_clk_en_out);
    c_flush: cover property (@(posedge clock_in) disable iff (!rstn_in)
        ext_pend[0] && sens_wr_ok ##1 !ext_pend[0]);
endmodule : ivw_ctrl
`default_nettype wire

// >>> ivw_cpu_model.sv
// CPU core model that takes requests and returns from service
`timescale 1ns/10ps
`default_nettype none
module ivw_cpu_model (
    input wire logic clock_in,        // Master clock
    input wire logic rstn_in,         // Async reset, active low
    input wire logic slow_in,         // Answer after idle cycles
    input wire logic irq_req_in,      // Request from controller
    input wire logic cc_push_in,      // Flags pushed
    input wire logic cc_push_mask_in, // Mask bit pushed
    output logic irq_ack_out,         // Takes the request
    output logic cc_pop_out,          // Flags popped at return
    output logic cc_pop_mask_out      // Mask bit popped
);
    int wait_cnt;
    int ret_cnt;
    logic saved_mask;
    // ------------------------------------------------------------
    // Take and return
    // ------------------------------------------------------------
    // Ack held until the edge that also sees the request
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_ack_out <= 1'b0;
            wait_cnt <= 0;
        end else if (irq_req_in && !irq_ack_out) begin
            irq_ack_out <= (wait_cnt >= (slow_in ? 5 : 0));
            wait_cnt <= wait_cnt + 1;
        end else begin
            irq_ack_out <= 1'b0;
            wait_cnt <= 0;
        end
    end
    // Stacked mask comes back a few cycles after the push
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cc_pop_out <= 1'b0;
            ret_cnt <= 0;
            saved_mask <= 1'b0;
        end else begin
            cc_pop_out <= 1'b0;
            if (cc_push_in) begin
                saved_mask <= cc_push_mask_in;
                ret_cnt <= 6;
            end else if (ret_cnt == 1) begin
                cc_pop_out <= 1'b1;
                ret_cnt <= 0;
            end else if (ret_cnt > 1) begin
                ret_cnt <= ret_cnt - 1;
            end
        end
    end
    assign cc_pop_mask_out = saved_mask;
endmodule : ivw_cpu_model
`default_nettype wire

// >>> ivw_ctrl_tb.sv
// Self-checking bench for the interrupt vector and wait controller
`timescale 1ns/10ps
`default_nettype none
module ivw_ctrl_tb
    import ivw_pkg::*;
;
    logic clock_in, rstn_in, wr, rd, pa, pb, pc, wait_instruction, mset, mclr, slow;
    logic req, push, pmask, imask, cpu_en, per_en, wt, swt, wake;
    logic ack, pop, popm;
    logic [7:0] addr, wdata, rdata;
    logic [13:0] periph;
    logic [1:0] halt;
    logic [3:0] vec;
    logic [15:0] vaddr;
    logic [31:0] seed = 32'h0000F177;
    int error_cnt = 0;
    int total_checks = 0;
    int q[$];
    int cnt, low;
    logic [13:0] bits;
    logic [7:0] x;
    int vl[9] = '{0, 4, 5, 6, 7, 8, 9, 12, 13};
    ivw_ctrl dut_u (.clock_in(clock_in), .rstn_in(rstn_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .porta_ext_irq_in(pa),
        .portb_ext_irq_in(pb), .portc_ext_irq_in(pc),
        .periph_irq_in(periph), .wait_instruction_in(wait_instruction),
        .mask_set_in(mset), .mask_clear_in(mclr), .cc_pop_in(pop),
        .cc_pop_mask_in(popm), .irq_ack_in(ack), .halt_kind_in(halt),
        .irq_req_out(req), .irq_vector_out(vec), .irq_addr_out(vaddr),
        .cc_push_out(push), .cc_push_mask_out(pmask),
        .imask_out(imask), .cpu_clk_en_out(cpu_en),
        .periph_clk_en_out(per_en), .wait_out(wt),
        .slow_wait_out(swt), .halt_wake_out(wake));
    ivw_cpu_model cpu_u (.clock_in(clock_in), .rstn_in(rstn_in),
        .slow_in(slow), .irq_req_in(req), .cc_push_in(push),
        .cc_push_mask_in(pmask), .irq_ack_out(ack), .cc_pop_out(pop),
        .cc_pop_mask_out(popm));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #12.5 clock_in = ~clock_in;
    // Xorshift source, fixed start for repeatable runs
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic hit(input int s);
        case (s)
            0: return req === 1'b1;
            1: return push === 1'b1;
            default: return imask === 1'b0;
        endcase
    endfunction : hit
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Bounded wait on a handshake; running out ends the run
    task automatic waitfor(input int s);
        int n;
        n = 0;
        do begin
            @(posedge clock_in);
            #1;
            n++;
        end while (!hit(s) && n < 80);
        if (!hit(s)) begin
            error_cnt++;
            $display("wrong value handshake %0d expected 1 seen 0", s);
            conclude();
        end
    endtask : waitfor
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, e);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask : rd_chk
    task automatic pulse(input int k);
        @(posedge clock_in);
        {wait_instruction, mset, mclr} <= 3'(4 >> k);
        @(posedge clock_in);
        {wait_instruction, mset, mclr} <= 3'h0;
    endtask : pulse
    // Expected vector comes from the model queue
    task automatic serve();
        int v;
        v = q.pop_front();
        waitfor(0);
        chk("vector", 16'(v), {12'h000, vec});
        chk("address", 16'hFFFA - 16'(2 * v), vaddr);
        // Sources are cleared only once taken, as a handler would;
        // a level request dropped early is never acknowledged
        waitfor(1);
        periph <= 14'h0000;
        {pc, pb, pa} <= 3'h7;
        chk("push_mask", 16'h0000, {15'h0000, pmask});
        @(posedge clock_in);
        #1;
        chk("imask", 16'h0001, {15'h0000, imask});
        waitfor(2);
    endtask : serve
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        rstn_in = 1'b0;
        {wr, rd, wait_instruction, mset, mclr, slow} = 6'h00;
        {pc, pb, pa} = 3'h7;
        {addr, wdata} = 16'h0000;
        periph = 14'h0000;
        halt = 2'h0;
        repeat (12) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        #1;
        chk("run_enables", 16'h0003, {14'h0000, cpu_en, per_en});
        rd_chk(IVW_SENS_OFS, IVW_SENS_RESET);
        rd_chk(IVW_CLK_OFS, 8'h04);
        rd_chk(8'h07, 8'h00);
        // Wake capability per halt kind, mask still set
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_in);
            halt <= 2'(k);
            periph <= 14'h0001;
            repeat (3) @(posedge clock_in);
            #1;
            chk("wake_timer", 16'(k == 3), {15'h0000, wake});
            @(posedge clock_in);
            periph <= 14'h0100;
            repeat (3) @(posedge clock_in);
            #1;
            chk("wake_ovf", 16'(k == 2), {15'h0000, wake});
        end
        @(posedge clock_in);
        periph <= 14'h0000;
        halt <= IVW_HALT_NONE;
        // Sense writes are dropped while the mask is clear
        pulse(2);
        wr_reg(IVW_SENS_OFS, 8'h15);
        rd_chk(IVW_SENS_OFS, 8'h00);
        pulse(1);
        x = 8'(xs()) & IVW_SENS_WMASK;
        wr_reg(IVW_SENS_OFS, x);
        rd_chk(IVW_SENS_OFS, x);
        // Each mode on port A, falling then rising
        for (int m = 0; m < 4; m++) begin
            wr_reg(IVW_SENS_OFS, 8'(m ^ 1));
            wr_reg(IVW_SENS_OFS, 8'(m));
            repeat (4) @(posedge clock_in);
            rd_chk(IVW_PEND_OFS, 8'h00);
            pa <= 1'b0;
            repeat (5) @(posedge clock_in);
            rd_chk(IVW_PEND_OFS, 8'(m != 1));
            wr_reg(IVW_SENS_OFS, 8'(m ^ 1));
            wr_reg(IVW_SENS_OFS, 8'(m));
            pa <= 1'b1;
            repeat (5) @(posedge clock_in);
            rd_chk(IVW_PEND_OFS, 8'(m != 2));
        end
        wr_reg(IVW_SENS_OFS, 8'h2A);
        // Vectors 0, 4 to 9, 12 and 13, prompt and slow answers alternating
        pulse(2);
        foreach (vl[i]) begin
            @(posedge clock_in);
            slow <= 1'(i);
            if (vl[i] < 4 || vl[i] > 6) periph <= 14'(1 << vl[i]);
            else {pc, pb, pa} <= ~3'(1 << (vl[i] - 4));
            q.push_back(vl[i]);
            serve();
        end
        // Several at once: lowest number wins
        repeat (3) begin
            pulse(1);
            bits = (14'(xs()) & IVW_PERIPH_USED) | 14'h2000;
            low = 0;
            while (!bits[low]) low++;
            periph <= bits;
            q.push_back(low);
            pulse(2);
            serve();
        end
        // Wait: mask cleared, CPU stopped until a request
        pulse(1);
        pulse(0);
        #1;
        chk("wait", 16'h0010, {11'h000, wt, imask, cpu_en, 2'h0});
        repeat (3) @(posedge clock_in);
        #1;
        chk("still_wait", 16'h0001, {15'h0000, wt});
        periph <= 14'h1000;
        q.push_back(12);
        serve();
        chk("woken", 16'h0000, {15'h0000, wt});
        // Slow mode: one peripheral tick per 32 clocks
        wr_reg(IVW_CLK_OFS, 8'h01);
        rd_chk(IVW_CLK_OFS, 8'h01);
        repeat (40) @(posedge clock_in);
        cnt = 0;
        repeat (64) begin
            @(posedge clock_in);
            #1;
            if (per_en === 1'b1) cnt++;
        end
        chk("slow_ticks", 16'h0002, 16'(cnt));
        pulse(0);
        #1;
        chk("slow_wait", 16'h0003, {14'h0000, wt, swt});
        periph <= 14'h2000;
        q.push_back(13);
        serve();
        wr_reg(IVW_CLK_OFS, 8'h00);
        conclude();
    end
endmodule : ivw_ctrl_tb
`default_nettype wire
